// ===== logic/spbg_serial_port.v
// Serial port with mode 0 shift engine, baud generator and APB register file
// Notes on behaviour
// R1: Two mode bits pick shift mode, 8-bit UART, fixed 9-bit or variable 9-bit UART.
// R2: Timer source allowed in modes 1 and 3; internal generator in modes 0, 1, 3.
// R3: Timer source tick is its overflow; baud_double doubles the rate.
// R4: Internal generator is 8-bit auto-reload, fed by pclk or pclk/6.
// R5: Internal generator ticks only while gen_run is set.
// R6: Mode 0 is half duplex: tx_pin clocks, rx_pin carries data.
// R7: Mode 0 shifts data least significant bit first both ways.
// R8: Software sets mode 0 then writes the shift buffer to start sending.
// R9: Each shift clock is low then high; D0 first cycle, D7 eighth.
// R10: After eighth transmit cycle rx_pin is driven high and tx_done_flag set.
// R11: Software receives by clearing mode bits and rx_done_flag, setting rx_allow.
// R12: Receive pulses clock, samples rx_pin each pulse, sets rx_done_flag after D7.
// R13: After reception a shift buffer read returns the assembled byte.
// R14: In mode 0 shift_mode_rate_source picks fixed or generator rate.
// R15: Fixed rate pclk/6; variable rate follows the generator formula.
// R16: In modes 1 and 3 separate bits pick receive and transmit sources.
// R17: Done flags stay set until software writes them clear.
// R18: Buffer writes during a mode 0 transfer leave the shifting byte intact.
`timescale 1ns/100ps
`include "spbg_regs.vh"

module spbg_serial_port (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Timer overflow, a one-cycle pulse from logic on pclk
   input wire timer_ovf,
   // Serial pins
   output reg tx_pin,
   input wire rx_pin_in,
   output reg rx_pin_out,
   output reg rx_pin_oe,
   // Rate ticks for the asynchronous engines
   output reg tx_baud_tick,
   output reg rx_baud_tick,
   // Interrupt
   output reg irq
);

   localparam ST_IDLE = 2'b00;
   localparam ST_TX = 2'b01;
   localparam ST_RX = 2'b10;

   reg [7:0] ctrl;
   reg [7:0] pwr;
   reg [7:0] bgc;
   reg [7:0] reload;
   reg [7:0] rx_buf;
   reg [1:0] istat;
   reg [1:0] ien;
   reg [1:0] state;
   reg [7:0] shreg;
   reg [2:0] bit_cnt;
   reg phase;
   reg [2:0] pre_cnt;
   reg [7:0] gen_cnt;
   reg gen_ovf;
   reg [1:0] fix_cnt;
   reg [4:0] m0_cnt;
   reg sync1;
   reg sync2;
   reg sync3;
   reg rx_level;
   reg rx_wait;
   reg [31:0] next_prdata;
   reg next_slverr;

   wire wr_en = psel & penable & pready & pwrite;
   wire [1:0] mode = {ctrl[`SPBG_CTRL_MODE_HI], ctrl[`SPBG_CTRL_MODE_LO]}; // R1
   wire mode0 = (mode == 2'b00);
   wire dbl = pwr[`SPBG_PWR_DOUBLE];
   wire run = bgc[`SPBG_BGC_RUN];
   wire wr_ctrl = wr_en & (paddr == `SPBG_ADDR_CTRL);
   wire wr_buf = wr_en & (paddr == `SPBG_ADDR_BUF);
   wire tx_start = wr_buf & mode0 & (state == ST_IDLE); // R8 R18
   wire rx_start = mode0 & (state == ST_IDLE) & ~wr_buf & ctrl[`SPBG_CTRL_RX_ALLOW] &
      ~ctrl[`SPBG_CTRL_RX_DONE]; // R11
   wire tx_end;
   wire rx_end;
   wire half_tick;
   wire [4:0] m0_top = dbl ? (`SPBG_OVF_HALF >> 1) : `SPBG_OVF_HALF;

   // APB answer: one wait-free access phase, data prepared in setup
   always @* begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      case (paddr)
         `SPBG_ADDR_CTRL: next_prdata = {24'h00_0000, ctrl};
         `SPBG_ADDR_BUF: next_prdata = {24'h00_0000, rx_buf}; // R13
         `SPBG_ADDR_PWR: next_prdata = {24'h00_0000, pwr};
         `SPBG_ADDR_BGC: next_prdata = {24'h00_0000, bgc};
         `SPBG_ADDR_RELOAD: next_prdata = {24'h00_0000, reload};
         `SPBG_ADDR_ISTAT: next_prdata = {30'h0, istat};
         `SPBG_ADDR_IEN: next_prdata = {30'h0, ien};
         `SPBG_ADDR_ICLR: next_prdata = 32'h0000_0000;
         default: next_slverr = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_slverr;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr <= `SPBG_RESET_BYTE;
         bgc <= `SPBG_RESET_BYTE;
         reload <= `SPBG_RESET_BYTE;
         ien <= 2'h0;
      end else if (wr_en) begin
         if (paddr == `SPBG_ADDR_PWR)
            pwr <= pwdata[7:0] & 8'h80;
         if (paddr == `SPBG_ADDR_BGC)
            bgc <= pwdata[7:0] & 8'h1F;
         if (paddr == `SPBG_ADDR_RELOAD)
            reload <= pwdata[7:0];
         if (paddr == `SPBG_ADDR_IEN)
            ien <= pwdata[1:0];
      end
   end

   // Control register; hardware set of a done flag beats a software clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SPBG_RESET_BYTE;
      end else begin
         if (wr_ctrl)
            ctrl <= pwdata[7:0] & 8'hD3;
         if (tx_end)
            ctrl[`SPBG_CTRL_TX_DONE] <= 1'b1; // R10 R17
         if (rx_end)
            ctrl[`SPBG_CTRL_RX_DONE] <= 1'b1; // R12 R17
      end
   end

   // Interrupt status, enable and clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat <= 2'h0;
         irq <= 1'b0;
      end else begin
         if (wr_en & (paddr == `SPBG_ADDR_ICLR))
            istat <= istat & ~pwdata[1:0] | {rx_end, tx_end};
         else
            istat <= istat | {rx_end, tx_end};
         irq <= |(istat & ien);
      end
   end

   // Internal generator: prescaler then 8-bit auto-reload counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt <= 3'h0;
         gen_cnt <= 8'h00;
         gen_ovf <= 1'b0;
      end else begin
         gen_ovf <= 1'b0;
         if (!run) begin
            pre_cnt <= 3'h0; // R5
            gen_cnt <= reload;
         end else begin
            pre_cnt <= (pre_cnt == `SPBG_PRESCALE) ? 3'h0 : pre_cnt + 3'h1;
            if (bgc[`SPBG_BGC_FAST] || pre_cnt == `SPBG_PRESCALE) begin // R4
               if (gen_cnt == 8'hFF) begin
                  gen_cnt <= reload;
                  gen_ovf <= 1'b1;
               end else begin
                  gen_cnt <= gen_cnt + 8'h01;
               end
            end
         end
      end
   end

   // Mode 0 half-bit enable: fixed pclk/6 per bit or generator overflows
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fix_cnt <= 2'h0;
         m0_cnt <= 5'h00;
      end else begin
         fix_cnt <= (fix_cnt == `SPBG_FIXED_HALF) ? 2'h0 : fix_cnt + 2'h1;
         if (gen_ovf)
            m0_cnt <= (m0_cnt >= m0_top) ? 5'h00 : m0_cnt + 5'h01;
      end
   end

   assign half_tick = bgc[`SPBG_BGC_M0_SRC] ? (gen_ovf & (m0_cnt >= m0_top)) :
      (fix_cnt == `SPBG_FIXED_HALF); // R14 R15

   // Asynchronous rate ticks, one divider per direction
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_rate
         reg [4:0] div;
         wire src_gen = (ch == 0) ? bgc[`SPBG_BGC_TX_SRC] : bgc[`SPBG_BGC_RX_SRC]; // R16
         wire src_ev = (mode == 2'b10) ? 1'b1 : (src_gen ? gen_ovf : timer_ovf); // R2 R3
         wire [4:0] top = dbl ? (`SPBG_OVF_BIT >> 1) : `SPBG_OVF_BIT;
         wire hit = ~mode0 & src_ev & (div >= top);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               div <= 5'h00;
            else if (mode0)
               div <= 5'h00;
            else if (src_ev)
               div <= (div >= top) ? 5'h00 : div + 5'h01;
         end
         if (ch == 0) begin : g_tx
            always @(posedge pclk or negedge presetn) begin
               if (!presetn)
                  tx_baud_tick <= 1'b0;
               else
                  tx_baud_tick <= hit;
            end
         end else begin : g_rx
            always @(posedge pclk or negedge presetn) begin
               if (!presetn)
                  rx_baud_tick <= 1'b0;
               else
                  rx_baud_tick <= hit;
            end
         end
      end
   endgenerate

   // Receive pin synchroniser; a change counts once stages two and three agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
         rx_level <= 1'b1;
      end else begin
         sync1 <= rx_pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3)
            rx_level <= sync3;
      end
   end

   assign tx_end = (state == ST_TX) & half_tick & phase & (bit_cnt == `SPBG_LAST_BIT);
   assign rx_end = (state == ST_RX) & half_tick & phase & (bit_cnt == `SPBG_LAST_BIT);

   // Mode 0 shift engine; a busy engine ignores new buffer writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         shreg <= `SPBG_RESET_BYTE;
         rx_buf <= `SPBG_RESET_BYTE;
         bit_cnt <= 3'h0;
         phase <= 1'b0;
         tx_pin <= 1'b1;
         rx_pin_out <= 1'b1;
         rx_pin_oe <= 1'b0;
         rx_wait <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               tx_pin <= 1'b1;
               bit_cnt <= 3'h0;
               phase <= 1'b0;
               if (tx_start) begin
                  state <= ST_TX; // R6
                  shreg <= pwdata[7:0];
                  rx_pin_out <= pwdata[0]; // R7 R9
                  rx_pin_oe <= 1'b1;
               end else if (rx_start) begin
                  state <= ST_RX;
                  rx_pin_oe <= 1'b0;
                  rx_wait <= 1'b1; // One idle half bit lets the released pin pass the synchroniser
               end
            end
            ST_TX: begin
               if (half_tick) begin
                  phase <= ~phase;
                  tx_pin <= phase; // R9
                  if (phase) begin
                     bit_cnt <= bit_cnt + 3'h1;
                     shreg <= {1'b1, shreg[7:1]}; // R7
                     rx_pin_out <= shreg[1];
                     if (bit_cnt == `SPBG_LAST_BIT) begin
                        rx_pin_out <= 1'b1; // R10
                        state <= ST_IDLE;
                     end
                  end
               end
            end
            ST_RX: begin
               if (!mode0 || !ctrl[`SPBG_CTRL_RX_ALLOW]) begin
                  state <= ST_IDLE;
               end else if (half_tick & rx_wait) begin
                  rx_wait <= 1'b0;
               end else if (half_tick) begin
                  phase <= ~phase;
                  tx_pin <= phase;
                  if (phase) begin
                     bit_cnt <= bit_cnt + 3'h1;
                     shreg <= {rx_level, shreg[7:1]}; // R7 R12
                     if (bit_cnt == `SPBG_LAST_BIT) begin
                        rx_buf <= {rx_level, shreg[7:1]}; // R13
                        state <= ST_IDLE;
                     end
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule // spbg_serial_port

// ===== logic/spbg_regs.vh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPBG_REGS_VH
`define SPBG_REGS_VH
`define SPBG_ADDR_CTRL 8'h00
`define SPBG_ADDR_BUF 8'h04
`define SPBG_ADDR_PWR 8'h08
`define SPBG_ADDR_BGC 8'h0C
`define SPBG_ADDR_RELOAD 8'h10
`define SPBG_ADDR_ISTAT 8'h14
`define SPBG_ADDR_IEN 8'h18
`define SPBG_ADDR_ICLR 8'h1C
`define SPBG_CTRL_MODE_HI 7
`define SPBG_CTRL_MODE_LO 6
`define SPBG_CTRL_RX_ALLOW 4
`define SPBG_CTRL_TX_DONE 1
`define SPBG_CTRL_RX_DONE 0
`define SPBG_PWR_DOUBLE 7
`define SPBG_BGC_RUN 4
`define SPBG_BGC_TX_SRC 3
`define SPBG_BGC_RX_SRC 2
`define SPBG_BGC_FAST 1
`define SPBG_BGC_M0_SRC 0
`define SPBG_IRQ_TX 0
`define SPBG_IRQ_RX 1
`define SPBG_RESET_BYTE 8'h00
`define SPBG_PRESCALE 3'h5
`define SPBG_FIXED_HALF 2'h2
`define SPBG_OVF_HALF 5'h0F
`define SPBG_OVF_BIT 5'h1F
`define SPBG_M2_BIT 5'h1F
`define SPBG_LAST_BIT 3'h7
`endif

// ===== verif/spbg_props.sv
// Checker for the APB handshake and the mode 0 pin timing
`timescale 1ns/100ps
module spbg_props (
   // Clock, reset and APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // Pins and tick
   input wire tx_pin,
   input wire rx_pin_out,
   input wire rx_pin_oe,
   input wire tx_baud_tick
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   setup_ready_a:
      assert property (psel && !penable |=> pready) else $error("ready late");
   ready_cause_a:
      assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
   ready_once_a: assert property (pready |=> !pready) else $error("long ready");
   error_ready_a: assert property (pslverr |-> pready) else $error("stray error");
   clock_high_a: assert property ($rose(tx_pin) |=> tx_pin [*2]) else $error("high");
   clock_low_a: assert property ($fell(tx_pin) |=> !tx_pin [*2]) else $error("low");
   data_hold_a:
      assert property ($fell(tx_pin) && rx_pin_oe |-> $stable(rx_pin_out)) else $error("data");
   tick_once_a: assert property (tx_baud_tick |=> !tx_baud_tick) else $error("tick");
endmodule // spbg_props
bind spbg_serial_port spbg_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .tx_pin(tx_pin),
   .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_baud_tick(tx_baud_tick));

// ===== verif/spbg_shift_partner.sv
// Behavioural external shift register on the mode 0 link
`timescale 1ns/100ps
module spbg_shift_partner (
   // Link pins
   input wire tx_pin,
   input wire rx_pin_out,
   input wire rx_pin_oe,
   output wire rx_pin_in,
   // Bench side
   input wire load,
   input wire [7:0] load_byte,
   output reg [7:0] got_byte
);
   reg [7:0] sr = 8'h00;
   reg drv = 1'b0;
   assign rx_pin_in = rx_pin_oe ? rx_pin_out : drv;
   always @(load) begin
      sr = load_byte;
      drv = sr[0];
   end
   // Capture mid-bit, where the data cannot be moving
   always @(negedge tx_pin) begin
      if (rx_pin_oe)
         got_byte = {rx_pin_out, got_byte[7:1]};
   end
   // Shift after the device sampled; refill keeps the wire changing
   always @(posedge tx_pin) begin
      if (!rx_pin_oe) begin
         sr = {~sr[7], sr[7:1]};
         drv = sr[0];
      end
   end
endmodule // spbg_shift_partner

// ===== verif/tb_top.sv
// Bench: APB driver, byte queue model, shift partner and tick counts
`timescale 1ns/100ps
`define CK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
$display("mismatch %0t %s", $time, m); end end
module tb_top;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg tov = 1'b0, ld = 1'b0, err;
   reg [7:0] paddr = 8'h00, b, lb = 8'h00;
   reg [31:0] pwdata = 32'h0, rd;
   reg [39:0] tab [0:3];
   wire [31:0] prdata;
   wire pready, pslverr, tx, rin, rout, roe, txt, rxt, irq;
   wire [7:0] got;
   integer mismatches = 0, samples_checked = 0, seed = 51, cyc = 0, n, k, t, i;
   int q[$];
   spbg_serial_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_ovf(tov), .tx_pin(tx), .rx_pin_in(rin), .rx_pin_out(rout),
      .rx_pin_oe(roe), .tx_baud_tick(txt), .rx_baud_tick(rxt), .irq(irq));
   spbg_shift_partner sp_u (.tx_pin(tx), .rx_pin_out(rout), .rx_pin_oe(roe),
      .rx_pin_in(rin), .load(ld), .load_byte(lb), .got_byte(got));
   initial forever #25 pclk = ~pclk;
   // Timer overflow every second cycle
   always @(posedge pclk) tov <= ~tov;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         stop_test;
      end
   end
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Bounded wait on irq (s) or on the shift clock
   task wt(input reg s, input reg v);
      for (n = 0; (s ? irq : tx) !== v && n < 900; n++) @(posedge pclk);
   endtask
   task fin_tx;
      begin
         wt(1'b1, 1'b1);
         `CK(irq, 1'b1, "tx irq")
         `CK(got, 8'(q.pop_front()), "tx byte")
         `CK(rout, 1'b1, "idle data")
         apb(1'b0, 8'h00, 32'h0);
         `CK(rd[1:0], 2'b10, "tx flag")
         apb(1'b1, 8'h00, 32'h0);
         apb(1'b1, 8'h1C, 32'h1);
      end
   endtask
   task send(input integer per);
      begin
         b = 8'($random(seed));
         q.push_back(b);
         apb(1'b1, 8'h04, {24'h0, b});
         wt(1'b0, 1'b0);
         wt(1'b0, 1'b1);
         t = cyc;
         wt(1'b0, 1'b0);
         wt(1'b0, 1'b1);
         `CK(cyc - t, per, "bit period")
         apb(1'b1, 8'h04, {24'h0, ~b});
         fin_tx;
      end
   endtask
   initial begin
      tab[0] = 40'h401A00140A;
      tab[1] = 40'hC016801428;
      tab[2] = 40'h8000802828;
      tab[3] = 40'h001B000000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      `CK(rd, 32'h0, "ctrl reset")
      apb(1'b0, 8'h20, 32'h0);
      `CK({err, rd}, 33'h100000000, "unmapped")
      apb(1'b1, 8'h18, 32'h3);
      apb(1'b1, 8'h00, 32'h0);
      send(6);
      apb(1'b1, 8'h10, 32'hFF);
      apb(1'b1, 8'h0C, 32'h13);
      for (i = 0; i < 2; i++) begin
         apb(1'b1, 8'h08, i << 7);
         send(32 >> i);
      end
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h0C, 32'h03);
      b = 8'($random(seed));
      q.push_back(b);
      apb(1'b1, 8'h04, {24'h0, b});
      n = 0;
      repeat (300) @(posedge pclk) n += (tx !== 1'b1);
      `CK(n, 0, "clock while stopped")
      apb(1'b1, 8'h0C, 32'h13);
      fin_tx;
      b = 8'($random(seed));
      lb <= b;
      ld <= ~ld;
      apb(1'b1, 8'h0C, 32'h0);
      apb(1'b1, 8'h00, 32'h10);
      wt(1'b1, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      `CK(rd, {24'h0, b}, "rx byte")
      apb(1'b1, 8'h18, 32'h1);
      repeat (2) @(posedge pclk);
      `CK(irq, 1'b0, "masked")
      apb(1'b1, 8'h18, 32'h3);
      repeat (2) @(posedge pclk);
      `CK(irq, 1'b1, "rx irq")
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h1C, 32'h2);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, 8'h00, {24'h0, tab[i][39:32]});
         apb(1'b1, 8'h0C, {24'h0, tab[i][31:24]});
         apb(1'b1, 8'h08, {24'h0, tab[i][23:16]});
         repeat (100) @(posedge pclk);
         n = 0;
         k = 0;
         repeat (640) begin
            @(posedge pclk);
            n += (txt === 1'b1);
            k += (rxt === 1'b1);
         end
         `CK(n, 32'(tab[i][15:8]), "tx ticks")
         `CK(k, 32'(tab[i][7:0]), "rx ticks")
      end
      stop_test;
   end
endmodule // tb_top
